/* hdl/dbgcs_regs.svh */
// Register offsets, field positions, reset values and codes of the debugger control block.
// Function
// - Acknowledge enabled: send FFH on breakpoint
// - Breakpoint, loop off: set debug bit
// - Breakpoint, loop on: CPU repeats it
// - Self-reset bit resets device, not debugger
// - Self-reset bit clears itself; writing zero ignored
// - Status bit 7: debug or breakpoint seen
// - Status bit 6: device in halt mode
// - Status bit 5: read-protect option active
// - Status reserved low bits read zero
// - Debug bit stops fetch; clearing resumes
// - Breakpoints disabled: opcode 00H is no-op
// - Read protection blocks clearing debug bit
`ifndef DBGCS_REGS_SVH
`define DBGCS_REGS_SVH

`define DBGCS_OFS_CONTROL 1'h0
`define DBGCS_OFS_STATUS 1'h1
`define DBGCS_CTL_DEBUG 7
`define DBGCS_CTL_BREAKPOINT_ENABLE 6
`define DBGCS_CTL_ACKEN 5
`define DBGCS_CTL_SPIN 4
`define DBGCS_CTL_RST 0
`define DBGCS_CTL_RSVD_MASK 8'h0E
`define DBGCS_CTL_RESET 8'h00
`define DBGCS_STAT_IDLE 7
`define DBGCS_STAT_HALT 6
`define DBGCS_STAT_PROT 5
`define DBGCS_STAT_RESET 8'h00
`define DBGCS_ACK_CHAR 8'hFF
`define DBGCS_BRK_OPCODE 8'h00
`define DBGCS_RST_CYCLES 16

`endif

/* hdl/dbgcs_pkg.sv */
// Types shared by the debugger control block.
`default_nettype none
package dbgcs_pkg;
    typedef enum logic [1:0] {
        DBGCS_RST_IDLE,
        DBGCS_RST_HOLD
    } dbgcs_rst_state_t;
endpackage : dbgcs_pkg
`default_nettype wire

/* hdl/dbgcs_reset_seq.sv */
// Self-reset sequencer: holds system reset for a fixed count, then reports done.
`timescale 1ns/1ps
`default_nettype none
`include "dbgcs_regs.svh"
module dbgcs_reset_seq #(
    parameter int HOLD_CYCLES = `DBGCS_RST_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    output logic sys_reset,
    output logic done
);
    localparam int CW = $clog2(HOLD_CYCLES + 1);

    if (HOLD_CYCLES < 1)
    begin : g_hold_check
        $error("HOLD_CYCLES must be at least 1");
    end

    dbgcs_pkg::dbgcs_rst_state_t state_reg;
    logic [CW-1:0] count_reg;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_reg <= dbgcs_pkg::DBGCS_RST_IDLE;
            count_reg <= '0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            case (state_reg)
                dbgcs_pkg::DBGCS_RST_IDLE:
                begin
                    if (start)
                    begin
                        state_reg <= dbgcs_pkg::DBGCS_RST_HOLD;
                        count_reg <= CW'(HOLD_CYCLES - 1);
                    end
                end
                dbgcs_pkg::DBGCS_RST_HOLD:
                begin
                    if (count_reg == '0)
                    begin
                        state_reg <= dbgcs_pkg::DBGCS_RST_IDLE;
                        done <= 1'b1;
                    end
                    else
                    begin
                        count_reg <= count_reg - 1'b1;
                    end
                end
                default: state_reg <= dbgcs_pkg::DBGCS_RST_IDLE;
            endcase
        end
    end

    assign sys_reset = (state_reg == dbgcs_pkg::DBGCS_RST_HOLD);
endmodule : dbgcs_reset_seq
`default_nettype wire

/* hdl/dbgcs_top.sv */
// Debugger control and status registers with breakpoint handling.
`timescale 1ns/1ps
`default_nettype none
`include "dbgcs_regs.svh"
module dbgcs_top #(
    parameter int RESET_HOLD_CYCLES = `DBGCS_RST_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic OPCODE_DECODED,
    input wire logic [7:0] OPCODE,
    input wire logic HALT_MODE,
    input wire logic READ_PROTECT_OPTION_N,
    output logic FETCH_STALL,
    output logic BRK_REPEAT,
    output logic BRK_AS_NOP,
    output logic SYS_RESET,
    output logic ACK_VALID,
    output logic [7:0] ACK_DATA,
    input wire logic ACK_READY
);
    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    logic [7:0] ctl_reg;
    logic seen_brk_reg;
    logic rst_done;
    logic rst_busy;
    logic protect_active_flag;
    logic ctl_wr;
    logic brk_hit;
    logic rst_start;
    logic [7:0] status_byte;

    // A sequence shorter than one cycle cannot hold the rest of the device.
    if (RESET_HOLD_CYCLES < 1)
    begin : g_hold_check
        $error("RESET_HOLD_CYCLES must be at least 1");
    end

    // The breakpoint opcode is decoded for both the enabled and the
    // disabled case, so the compare lives in one place.
    function automatic logic is_brk_opcode(input logic [7:0] op);
        return op == `DBGCS_BRK_OPCODE;
    endfunction : is_brk_opcode

    assign protect_active_flag = ~READ_PROTECT_OPTION_N;
    assign ctl_wr = REG_WR && (REG_ADDR == `DBGCS_OFS_CONTROL);
    assign brk_hit = OPCODE_DECODED && is_brk_opcode(OPCODE)
        && ctl_reg[`DBGCS_CTL_BREAKPOINT_ENABLE];
    // start refused while busy
    // A second request during a running sequence is dropped rather than
    // queued, so the device never sees two back-to-back reset pulses.
    assign rst_start = ctl_wr && REG_WDATA[`DBGCS_CTL_RST] && !rst_busy;

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    // The register only sees SRST, never the self-reset it triggers, so the
    // debugger keeps its state across that sequence.
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            ctl_reg <= `DBGCS_CTL_RESET;
        end
        else
        begin
            if (ctl_wr)
            begin
                // reserved bits zero
                // Reserved bits are never loaded, so they read zero even if a
                // host ignores the rule and writes ones there.
                ctl_reg[`DBGCS_CTL_BREAKPOINT_ENABLE] <= REG_WDATA[`DBGCS_CTL_BREAKPOINT_ENABLE];
                ctl_reg[`DBGCS_CTL_ACKEN] <= REG_WDATA[`DBGCS_CTL_ACKEN];
                ctl_reg[`DBGCS_CTL_SPIN] <= REG_WDATA[`DBGCS_CTL_SPIN];
                if (REG_WDATA[`DBGCS_CTL_DEBUG] || !protect_active_flag)
                begin
                    ctl_reg[`DBGCS_CTL_DEBUG] <= REG_WDATA[`DBGCS_CTL_DEBUG];
                end
            end
            if (brk_hit && !ctl_reg[`DBGCS_CTL_SPIN])
            begin
                ctl_reg[`DBGCS_CTL_DEBUG] <= 1'b1;
            end
            if (rst_start)
            begin
                ctl_reg[`DBGCS_CTL_RST] <= 1'b1;
            end
            else if (rst_done)
            begin
                ctl_reg[`DBGCS_CTL_RST] <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Breakpoint history
    // ----------------------------------------------------------------
    // A breakpoint in the same cycle as a control write still counts.
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            seen_brk_reg <= 1'b0;
        end
        else if (brk_hit)
        begin
            seen_brk_reg <= 1'b1;
        end
        else if (ctl_wr)
        begin
            seen_brk_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Self-reset sequence
    // ----------------------------------------------------------------
    // device reset sequence
    dbgcs_reset_seq #(
        .HOLD_CYCLES(RESET_HOLD_CYCLES)
    ) u_reset_seq (
        .clk(CORE_CLK),
        .srst(SRST),
        .start(rst_start),
        .sys_reset(SYS_RESET),
        .done(rst_done)
    );
    // The bit itself marks the sequence as busy until it clears.
    assign rst_busy = ctl_reg[`DBGCS_CTL_RST];

    // ----------------------------------------------------------------
    // CPU controls
    // ----------------------------------------------------------------
    // The stall follows the register, so the CPU halts from the edge
    // that sets the bit until the edge that clears it.
    // debug stops fetch
    assign FETCH_STALL = ctl_reg[`DBGCS_CTL_DEBUG];
    assign BRK_REPEAT = brk_hit && ctl_reg[`DBGCS_CTL_SPIN];
    // With breakpoints off the CPU treats the opcode as a plain no-op.
    // disabled breakpoint nop
    assign BRK_AS_NOP = OPCODE_DECODED && is_brk_opcode(OPCODE)
        && !ctl_reg[`DBGCS_CTL_BREAKPOINT_ENABLE];

    // ----------------------------------------------------------------
    // Acknowledge character
    // ----------------------------------------------------------------
    // One character is held until the serial side takes it; a second
    // breakpoint while pending merges into it.
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            ACK_VALID <= 1'b0;
            ACK_DATA <= 8'h00;
        end
        else if (brk_hit && ctl_reg[`DBGCS_CTL_ACKEN])
        begin
            ACK_VALID <= 1'b1;
            ACK_DATA <= `DBGCS_ACK_CHAR;
        end
        else if (ACK_READY)
        begin
            ACK_VALID <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Status byte
    // ----------------------------------------------------------------
    // The byte is formed live, so a read always reports the state at the
    // edge that takes it.
    always_comb
    begin
        status_byte = `DBGCS_STAT_RESET;
        status_byte[`DBGCS_STAT_IDLE] = ctl_reg[`DBGCS_CTL_DEBUG] | seen_brk_reg;
        status_byte[`DBGCS_STAT_HALT] = HALT_MODE;
        status_byte[`DBGCS_STAT_PROT] = protect_active_flag;
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Read data is registered and stands until the next read strobe.
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            REG_RDATA <= `DBGCS_STAT_RESET;
        end
        else if (REG_RD)
        begin
            if (REG_ADDR == `DBGCS_OFS_CONTROL)
            begin
                REG_RDATA <= ctl_reg & ~`DBGCS_CTL_RSVD_MASK;
            end
            else
            begin
                REG_RDATA <= status_byte;
            end
        end
    end
endmodule : dbgcs_top
`default_nettype wire

/* test/dbgcs_props.sv */
// Port checker for the debugger control block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module dbgcs_props #(parameter int RESET_HOLD_CYCLES = 16) (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic REG_RD,
    input wire logic REG_ADDR,
    input wire logic [7:0] REG_RDATA,
    input wire logic OPCODE_DECODED,
    input wire logic [7:0] OPCODE,
    input wire logic HALT_MODE,
    input wire logic READ_PROTECT_OPTION_N,
    input wire logic FETCH_STALL,
    input wire logic BRK_REPEAT,
    input wire logic BRK_AS_NOP,
    input wire logic SYS_RESET,
    input wire logic ACK_VALID,
    input wire logic [7:0] ACK_DATA,
    input wire logic ACK_READY
);
    // A counter is used because the pulse length is a parameter, not a fixed repeat.
    logic [7:0] cnt_reg;
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
            cnt_reg <= 8'h00;
        else
            cnt_reg <= SYS_RESET ? cnt_reg + 8'h01 : 8'h00;
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    sequence s_rd; REG_RD && REG_ADDR; endsequence
    sequence s_brk; OPCODE_DECODED && OPCODE == 8'h00; endsequence
    AST_HALT: assert property (s_rd |=> REG_RDATA[6] == $past(HALT_MODE))
        else $error("halt flag wrong");
    AST_PROT: assert property (s_rd |=> REG_RDATA[5] != $past(READ_PROTECT_OPTION_N))
        else $error("protect flag wrong");
    AST_LOW: assert property (s_rd |=> REG_RDATA[4:0] == 5'h00)
        else $error("low status bits set");
    AST_IDLE: assert property (s_rd ##0 FETCH_STALL |=> REG_RDATA[7])
        else $error("idle flag low");
    AST_DBG: assert property (s_brk ##0 (!BRK_REPEAT && !BRK_AS_NOP) |=> FETCH_STALL)
        else $error("no debug entry");
    AST_SPIN: assert property (BRK_REPEAT |-> s_brk ##1 !$rose(FETCH_STALL))
        else $error("loop entered debug");
    AST_NOP: assert property (BRK_AS_NOP |-> s_brk ##0 !BRK_REPEAT ##1 !$rose(FETCH_STALL))
        else $error("disabled break acted");
    AST_RST: assert property ($fell(SYS_RESET) |-> cnt_reg == 8'(RESET_HOLD_CYCLES))
        else $error("self reset length wrong");
    AST_ACK_HOLD: assert property (ACK_VALID && !ACK_READY |=> ACK_VALID && $stable(ACK_DATA))
        else $error("pending character dropped");
    AST_ACK_CHAR: assert property (ACK_VALID |-> ACK_DATA == 8'hFF)
        else $error("acknowledge character wrong");
endmodule : dbgcs_props
bind dbgcs_top dbgcs_props #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)) u_props (.*);
`default_nettype wire

/* test/dbgcs_host_model.sv */
// Debug host model that takes acknowledge characters, promptly or slowly.
`timescale 1ns/1ps
`default_nettype none
module dbgcs_host_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic ack_valid,
    input wire logic [7:0] ack_data,
    output logic ack_ready = 1'b0,
    output int n_acks = 0
);
    // A slow host keeps ready low for two edges after a character appears,
    // so the character has to stay pending across one stalled edge.
    logic stall_done = 1'b0;
    always @(negedge clk)
    begin
        stall_done <= slow && ack_valid && !ack_ready;
        ack_ready <= !slow || stall_done;
    end
    always @(posedge clk)
        if (ack_valid && ack_ready && ack_data == 8'hFF)
            n_acks <= n_acks + 1;
endmodule : dbgcs_host_model
`default_nettype wire

/* test/dbgcs_top_tb_top.sv */
// Self-checking bench for the debugger control block.
`timescale 1ns/1ps
`default_nettype none
module dbgcs_top_tb_top;
    logic CORE_CLK = 0, SRST = 1, REG_WR = 0, REG_RD = 0, REG_ADDR = 0, OPCODE_DECODED = 0;
    logic HALT_MODE = 0, READ_PROTECT_OPTION_N = 1, FETCH_STALL, BRK_REPEAT, BRK_AS_NOP;
    logic SYS_RESET, ACK_VALID, ACK_READY, slow = 0;
    logic [7:0] REG_WDATA = 8'h00, OPCODE = 8'h00, REG_RDATA, ACK_DATA;
    logic [1:0] rn;
    int errors = 0, n_checks = 0, n_acks, i;
    dbgcs_top #(.RESET_HOLD_CYCLES(2)) uut (.*);
    dbgcs_host_model host (.clk(CORE_CLK), .slow(slow), .ack_valid(ACK_VALID),
        .ack_data(ACK_DATA), .ack_ready(ACK_READY), .n_acks(n_acks));
    initial forever #2 CORE_CLK = ~CORE_CLK;
    // ----------------------------------------
    // Access tasks and verdict
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        errors += int'(got !== exp);
        if (got !== exp)
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    endtask : chk
    task automatic acc(input logic w, input logic a, input logic [7:0] d, input logic [7:0] e);
        @(negedge CORE_CLK);
        {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {w, !w, a, d};
        @(negedge CORE_CLK);
        {REG_WR, REG_RD} = 2'h0;
        if (!w)
            chk(REG_RDATA, e);
    endtask : acc
    task automatic dec(input logic [7:0] e);
        @(negedge CORE_CLK);
        OPCODE_DECODED = 1'b1;
        #1 rn = {BRK_REPEAT, BRK_AS_NOP};
        @(negedge CORE_CLK);
        OPCODE_DECODED = 1'b0;
        chk({5'h00, rn, FETCH_STALL}, e);
    endtask : dec
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (16) @(negedge CORE_CLK);
        {SRST, HALT_MODE} = 2'h1;
        acc(0, 1, 8'h00, 8'h40);
        HALT_MODE = 1'b0;
        dec(8'h02);
        acc(1, 0, 8'h50, 8'h00);
        dec(8'h04);
        acc(0, 1, 8'h00, 8'h80);
        acc(1, 0, 8'h60, 8'h00);
        acc(1, 1, 8'h9F, 8'h00);
        acc(0, 0, 8'h00, 8'h60);
        acc(0, 1, 8'h00, 8'h00);
        $display("status done");
        slow <= 1'b1;
        dec(8'h01);
        chk({7'h00, ACK_VALID}, 8'h01);
        chk(ACK_DATA, 8'hFF);
        for (i = 0; i < 20 && n_acks == 0; i++)
            @(negedge CORE_CLK);
        chk(n_acks[7:0], 8'h01);
        if (n_acks != 1)
            test_done();
        acc(1, 0, 8'h40, 8'h00);
        chk({7'h00, FETCH_STALL}, 8'h00);
        dec(8'h01);
        repeat (4) @(negedge CORE_CLK);
        chk({ACK_VALID, n_acks[6:0]}, 8'h01);
        $display("breakpoint done");
        acc(1, 0, 8'h81, 8'h00);
        chk({6'h00, SYS_RESET, FETCH_STALL}, 8'h03);
        for (i = 0; i < 10 && SYS_RESET; i++)
            @(negedge CORE_CLK);
        chk({7'h00, SYS_RESET}, 8'h00);
        if (SYS_RESET)
            test_done();
        @(negedge CORE_CLK);
        acc(0, 0, 8'h00, 8'h80);
        READ_PROTECT_OPTION_N = 1'b0;
        acc(0, 1, 8'h00, 8'hA0);
        acc(1, 0, 8'h40, 8'h00);
        chk({7'h00, FETCH_STALL}, 8'h01);
        $display("reset done");
        test_done();
    end
endmodule : dbgcs_top_tb_top
`default_nettype wire
